// >>> hpc_map.svh
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH
// Hard-init stretch after the pin is released, in ns, and its count in core cycles.
`define HPC_CLK_PERIOD_NS 100
`define HPC_INIT_HOLD_NS  1000
`define HPC_INIT_CYCLES   ((`HPC_INIT_HOLD_NS + `HPC_CLK_PERIOD_NS - 1) / `HPC_CLK_PERIOD_NS)
// Pin-sampler reset values: select and power-down idle high, gate idle low.
`define HPC_SEL_RST       1'b1
`define HPC_PDN_RST       1'b1
`define HPC_GATE_RST      1'b0
`define HPC_CS_RST        1'b1
`define HPC_INIT_RST      1'b0
`endif

// >>> hpc_pkg.sv
package hpc_pkg;
  typedef enum logic [2:0] {
    HPC_MODE_I2C  = 3'b001,
    HPC_MODE_SPI3 = 3'b010,
    HPC_MODE_SPI4 = 3'b100
  } hpc_mode_t;
endpackage

// >>> hpc_pins.sv
// Functional notes
// - The host port runs as I2C when the select pin is 1 and as SPI when 0, defaulting to I2C.
// - The data pin is open-drain I2C data, two-way 3-wire SPI data, or 4-wire SPI data input.
// - The address-1 pin is an address input in I2C and the driven data output in 4-wire SPI.
// - The address-0 pin is an address input in I2C and an active-low host chip select in SPI.
// - The interrupt output pulls low on a status change and never drives high.
// - The device enters low power while the power-down input is low.
// - An unconnected power-down input reads as inactive.
// - While hard init is low, the core is held busy: the interrupt clears and clock outputs and data drive stay off.
// - Clock outputs stay disabled while hard init is in progress.
// - Clock outputs are disabled while the gate input is high and enabled when it floats.
`timescale 1ns/1ps
`include "hpc_map.svh"
`default_nettype none
module hpc_pins
  import hpc_pkg::*;
#(
  parameter int INIT_CYCLES = `HPC_INIT_CYCLES
) (
  // Core clock and reset.
  input  wire logic       clk,
  input  wire logic       nrst,
  // Host serial pins.
  input  wire logic       serial_clk,
  input  wire logic       i2c_select,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_bit1_or_data_out_in,
  output logic            addr_bit1_or_data_out_out,
  output logic            addr_bit1_or_data_out_oe,
  input  wire logic       addr_bit0_or_chip_select_n,
  // Control and status pins.
  output logic            status_change_irq_n_out,
  output logic            status_change_irq_n_oe,
  input  wire logic       low_power_request_n,
  input  wire logic       hard_init_n,
  input  wire logic       output_gate_n,
  // Protocol engine side.
  input  wire logic       spi_four_wire,
  input  wire logic       eng_sda_pull_low,
  input  wire logic       eng_tx_bit,
  input  wire logic       eng_sdio_drive,
  output hpc_mode_t       port_mode,
  output logic [1:0]      i2c_addr,
  output logic            spi_selected,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  // Device core side.
  input  wire logic       status_event,
  input  wire logic       status_clear,
  output logic            low_power,
  output logic            clk_out_enable,
  output logic            core_init_busy
);

  ////////////////////////////////////////////////////////////////////////////
  logic      sel_s1_ff, sel_s2_ff, pdn_s1_ff, pdn_s2_ff, gate_s1_ff, gate_s2_ff;
  logic      cs_s1_ff, cs_s2_ff, init_s1_ff, init_s2_ff, a1_s1_ff, a1_s2_ff;
  hpc_mode_t mode_ff;
  logic      init_busy_ff, irq_ff, low_power_ff, out_en_ff, tx_bit_ff;
  logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt_ff;
  logic [1:0] addr_ff;
  logic       cs_act_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_s1_ff  <= `HPC_SEL_RST;
      sel_s2_ff  <= `HPC_SEL_RST;
      pdn_s1_ff  <= `HPC_PDN_RST;
      pdn_s2_ff  <= `HPC_PDN_RST;
      gate_s1_ff <= `HPC_GATE_RST;
      gate_s2_ff <= `HPC_GATE_RST;
      cs_s1_ff   <= `HPC_CS_RST;
      cs_s2_ff   <= `HPC_CS_RST;
      init_s1_ff <= `HPC_INIT_RST;
      init_s2_ff <= `HPC_INIT_RST;
      a1_s1_ff   <= 1'b0;
      a1_s2_ff   <= 1'b0;
    end else begin
      sel_s1_ff  <= i2c_select;
      sel_s2_ff  <= sel_s1_ff;
      pdn_s1_ff  <= low_power_request_n;
      pdn_s2_ff  <= pdn_s1_ff;
      gate_s1_ff <= output_gate_n;
      gate_s2_ff <= gate_s1_ff;
      cs_s1_ff   <= addr_bit0_or_chip_select_n;
      cs_s2_ff   <= cs_s1_ff;
      init_s1_ff <= hard_init_n;
      init_s2_ff <= init_s1_ff;
      a1_s1_ff   <= addr_bit1_or_data_out_in;
      a1_s2_ff   <= a1_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // init stretch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_busy_ff <= 1'b1;
      init_cnt_ff  <= '0;
    end else if (!init_s2_ff) begin
      init_busy_ff <= 1'b1;
      init_cnt_ff  <= '0;
    end else if (init_cnt_ff == INIT_CYCLES[$bits(init_cnt_ff)-1:0]) begin
      init_busy_ff <= 1'b0;
    end else begin
      init_cnt_ff  <= init_cnt_ff + 1'b1;
    end
  end

  // The mode is decoded only during init and frozen after it, so the engine never sees it change mid-frame.
  // mode decode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= HPC_MODE_I2C;
    end else if (init_busy_ff) begin
      if (sel_s2_ff) begin
        mode_ff <= HPC_MODE_I2C;
      end else if (spi_four_wire) begin
        mode_ff <= HPC_MODE_SPI4;
      end else begin
        mode_ff <= HPC_MODE_SPI3;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff   <= 2'h0;
      cs_act_ff <= 1'b0;
    end else begin
      addr_ff   <= (mode_ff == HPC_MODE_I2C) ? {a1_s2_ff, cs_s2_ff} : 2'h0;
      cs_act_ff <= (mode_ff != HPC_MODE_I2C) && !cs_s2_ff && !init_busy_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else if (init_busy_ff) begin
      irq_ff <= 1'b0;
    end else if (status_event) begin
      irq_ff <= 1'b1;
    end else if (status_clear) begin
      irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_power_ff <= 1'b0;
      out_en_ff    <= 1'b0;
      tx_bit_ff    <= 1'b0;
    end else begin
      low_power_ff <= !pdn_s2_ff;
      out_en_ff    <= !init_busy_ff && !gate_s2_ff;
      tx_bit_ff    <= init_busy_ff ? 1'b0 : eng_tx_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host clock domain
  logic [7:0] shift_ff, byte_ff;
  logic [2:0] bit_cnt_ff;
  logic       tog_ff, tog_s1_ff, tog_s2_ff, tog_s3_ff;
  logic       frame_rst_n;
  logic [7:0] rx_byte_ff;
  logic       rx_valid_ff;

  // A deselected chip select ends the frame without needing another serial clock edge.
  assign frame_rst_n = nrst && !((mode_ff != HPC_MODE_I2C) && addr_bit0_or_chip_select_n);

  always_ff @(posedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_ff   <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else begin
      shift_ff   <= {shift_ff[6:0], sda_in};
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  // Bytes must be at least four core cycles apart; faster bytes overwrite the hold register.
  always_ff @(posedge serial_clk or negedge nrst) begin
    if (!nrst) begin
      byte_ff <= 8'h00;
      tog_ff  <= 1'b0;
    end else if (frame_rst_n && bit_cnt_ff == 3'h7) begin
      byte_ff <= {shift_ff[6:0], sda_in};
      tog_ff  <= !tog_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tog_s1_ff   <= 1'b0;
      tog_s2_ff   <= 1'b0;
      tog_s3_ff   <= 1'b0;
      rx_byte_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else begin
      tog_s1_ff   <= tog_ff;
      tog_s2_ff   <= tog_s1_ff;
      tog_s3_ff   <= tog_s2_ff;
      rx_valid_ff <= tog_s2_ff != tog_s3_ff;
      if (tog_s2_ff != tog_s3_ff) begin
        rx_byte_ff <= byte_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data pin drive
  assign sda_out = (mode_ff == HPC_MODE_I2C) ? 1'b0 : tx_bit_ff;
  assign sda_oe  = (mode_ff == HPC_MODE_I2C) ? (eng_sda_pull_low && !init_busy_ff)
                 : ((mode_ff == HPC_MODE_SPI3) && cs_act_ff && eng_sdio_drive);
  assign addr_bit1_or_data_out_out = tx_bit_ff;
  assign addr_bit1_or_data_out_oe  = (mode_ff == HPC_MODE_SPI4) && cs_act_ff;
  assign status_change_irq_n_out = 1'b0;
  assign status_change_irq_n_oe  = irq_ff;
  assign port_mode      = mode_ff;
  assign i2c_addr       = addr_ff;
  assign spi_selected   = cs_act_ff;
  assign rx_byte        = rx_byte_ff;
  assign rx_valid       = rx_valid_ff;
  assign low_power      = low_power_ff;
  assign clk_out_enable = out_en_ff;
  assign core_init_busy = init_busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_i2c_mode;
    sel_s2_ff && init_busy_ff |=> mode_ff == HPC_MODE_I2C;
  endproperty
  a_i2c_mode: assert property (p_i2c_mode) else $error("Mode not I2C with select high.");
  property p_sda_open_drain;
    mode_ff == HPC_MODE_I2C && sda_oe |-> !sda_out;
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain) else $error("SDA driven high.");
  property p_sdo_only_spi4;
    addr_bit1_or_data_out_oe |-> mode_ff == HPC_MODE_SPI4;
  endproperty
  a_sdo_only_spi4: assert property (p_sdo_only_spi4) else $error("SDO driven outside SPI4.");
  property p_cs_spi_only;
    spi_selected |-> mode_ff != HPC_MODE_I2C && $past(!cs_s2_ff);
  endproperty
  a_cs_spi_only: assert property (p_cs_spi_only) else $error("Select active wrongly.");
  property p_irq_set;
    !init_busy_ff && status_event |=> status_change_irq_n_oe && !status_change_irq_n_out;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("Status event lost.");
  property p_low_power;
    !pdn_s2_ff |=> low_power;
  endproperty
  a_low_power: assert property (p_low_power) else $error("Low power not entered.");
  property p_pdn_idle;
    pdn_s2_ff |=> !low_power;
  endproperty
  a_pdn_idle: assert property (p_pdn_idle) else $error("Low power without request.");
  property p_init_hold;
    !init_s2_ff |=> init_busy_ff [*2];
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("Init released early.");
  property p_init_off;
    init_busy_ff |=> !clk_out_enable;
  endproperty
  a_init_off: assert property (p_init_off) else $error("Outputs on during init.");
  property p_gate_off;
    gate_s2_ff |=> !clk_out_enable;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("Outputs on while gated.");
  property p_sdo_release;
    cs_s2_ff |=> !addr_bit1_or_data_out_oe && !(sda_oe && mode_ff != HPC_MODE_I2C);
  endproperty
  a_sdo_release: assert property (p_sdo_release) else $error("Data driven while idle.");

  c_spi4_drive: cover property (addr_bit1_or_data_out_oe);
  c_rx_byte:    cover property (rx_valid);
  c_irq:        cover property (status_change_irq_n_oe);
  c_out_on:     cover property ($rose(clk_out_enable));

endmodule
`default_nettype wire

// >>> hpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_host (
  // Host serial pins.
  output logic serial_clk,
  output logic sda,
  output logic cs_n
);
  initial begin
    serial_clk = 1'b0;
    sda = 1'b1;
    cs_n = 1'b1;
  end
  task automatic sel(input logic v);
    cs_n = v;
  endtask
  // host clock
  // The clock stands low between frames, so a byte is exactly eight rising edges.
  task automatic send(input logic [7:0] b, input logic spi);
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    // line released
    // Released in SPI shows a changed level, so a stale bit cannot pass as data.
    sda = spi ? ~b[0] : 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb_hpc_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hpc_pins;
  import hpc_pkg::*;
  localparam int IC = 2;
  logic       clk, nrst, i2c_select, a1, a0, lpr_n, hinit_n, gate_n, four;
  logic       pull_low, tx_bit, sdio_drive, st_ev, st_clr;
  logic       sda_out, sda_oe, a1_out, a1_oe, irq_out, irq_oe, spi_sel, rx_valid;
  logic       low_power, clk_en, busy;
  hpc_mode_t  port_mode;
  logic [1:0] i2c_addr;
  logic [7:0] rx_byte;
  logic [7:0] exp_q[$];
  logic [31:0] seed;
  int         n_errors, checks;
  wire logic  sclk, h_sda, cs_n;
  wire logic  sda_pin = sda_oe ? sda_out : h_sda;
  wire logic  a1_pin = a1_oe ? a1_out : a1;
  wire logic  a0_pin = i2c_select ? a0 : cs_n;
  ////////////////////////////////////////////////////////////////////////////
  hpc_host hpc_host_i (.serial_clk(sclk), .sda(h_sda), .cs_n(cs_n));
  hpc_pins #(.INIT_CYCLES(IC)) hpc_pins_i (
    .clk(clk), .nrst(nrst), .serial_clk(sclk), .i2c_select(i2c_select),
    .sda_in(sda_pin), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_bit1_or_data_out_in(a1_pin), .addr_bit1_or_data_out_out(a1_out),
    .addr_bit1_or_data_out_oe(a1_oe), .addr_bit0_or_chip_select_n(a0_pin),
    .status_change_irq_n_out(irq_out), .status_change_irq_n_oe(irq_oe),
    .low_power_request_n(lpr_n), .hard_init_n(hinit_n), .output_gate_n(gate_n),
    .spi_four_wire(four), .eng_sda_pull_low(pull_low), .eng_tx_bit(tx_bit),
    .eng_sdio_drive(sdio_drive), .port_mode(port_mode), .i2c_addr(i2c_addr),
    .spi_selected(spi_sel), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .status_event(st_ev), .status_clear(st_clr), .low_power(low_power),
    .clk_out_enable(clk_en), .core_init_busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_init;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      step(1);
      n++;
    end
    // The clock output enable follows busy by one more edge.
    step(1);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Received bytes are compared in arrival order against the driver's notes.
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) check(rx_valid, 1'b0);
      else check(rx_byte, exp_q.pop_front());
    end
  end
  initial begin
    #100000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, nrst, a0, four, pull_low, tx_bit, sdio_drive, st_ev, st_clr, gate_n} = '0;
    {i2c_select, a1, lpr_n, hinit_n} = '1;
    seed = 32'd11111;
    step(10);
    nrst = 1'b1;
    wait_init();
    check(busy, 1'b0);
    check(port_mode, HPC_MODE_I2C);
    check(i2c_addr, 2'b10);
    check(clk_en, 1'b1);
    check(low_power, 1'b0);
    pull_low = 1'b1;
    step(1);
    check({sda_oe, sda_out}, 2'b10);
    pull_low = 1'b0;
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      exp_q.push_back(seed[7:0]);
      hpc_host_i.send(seed[7:0], 1'b0);
      step(6);
    end
    $display("i2c test done");
    lpr_n = 1'b0;
    gate_n = 1'b1;
    step(4);
    check(low_power, 1'b1);
    check(clk_en, 1'b0);
    lpr_n = 1'b1;
    gate_n = 1'b0;
    step(4);
    check({low_power, clk_en}, 2'b01);
    st_ev = 1'b1;
    step(2);
    check({irq_oe, irq_out}, 2'b10);
    st_clr = 1'b1;
    step(2);
    check(irq_oe, 1'b1);
    st_ev = 1'b0;
    step(2);
    check(irq_oe, 1'b0);
    st_clr = 1'b0;
    st_ev = 1'b1;
    step(1);
    st_ev = 1'b0;
    $display("control test done");
    // SPI mode is latched only during init, so the switch rides on a hard init.
    hinit_n = 1'b0;
    i2c_select = 1'b0;
    four = 1'b1;
    step(4);
    check({busy, clk_en, irq_oe}, 3'b100);
    hinit_n = 1'b1;
    wait_init();
    check(port_mode, HPC_MODE_SPI4);
    check({i2c_addr, a1_oe, sda_oe}, 4'b0000);
    hpc_host_i.sel(1'b0);
    step(4);
    check({spi_sel, a1_oe, sda_oe}, 3'b110);
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      tx_bit = seed[0];
      step(2);
      check(a1_pin, seed[0]);
    end
    seed = xs(seed);
    exp_q.push_back(seed[7:0]);
    hpc_host_i.send(seed[7:0], 1'b1);
    step(6);
    hpc_host_i.sel(1'b1);
    step(4);
    check({spi_sel, a1_oe}, 2'b00);
    check(exp_q.size(), 0);
    $display("spi test done");
    four = 1'b0;
    hinit_n = 1'b0;
    step(4);
    hinit_n = 1'b1;
    wait_init();
    check(port_mode, HPC_MODE_SPI3);
    sdio_drive = 1'b1;
    hpc_host_i.sel(1'b0);
    step(4);
    check({sda_oe, a1_oe}, 2'b10);
    seed = xs(seed);
    tx_bit = seed[0];
    step(2);
    check(sda_pin, seed[0]);
    hpc_host_i.sel(1'b1);
    step(4);
    check(sda_oe, 1'b0);
    sdio_drive = 1'b0;
    $display("spi3 test done");
    final_report();
  end
endmodule
`default_nettype wire
